// ### hdl/dcod_table.sv
// Combinational opcode table: class, flag actions, exceptions, operands.
`timescale 1ns/1ns
`default_nettype none
module dcod_table (
  input wire logic [7:0] opcode,
  output logic known,
  output logic emulated,
  output logic [7:0] flag_act,
  output logic [6:0] exc_allowed,
  output logic [2:0] operand_count,
  output logic stack_push,
  output logic [2:0] mode_target
);
  // Builds the four two-bit actions for N, Z, V, C in that order.
  function automatic logic [7:0] acts(input logic [1:0] n,
      input logic [1:0] z, input logic [1:0] v, input logic [1:0] c);
    acts = {n, z, v, c};
  endfunction : acts

  // One lookup; unknown opcodes fall to the default branch.
  always_comb begin
    known = 1'b1;
    emulated = 1'b0;
    flag_act = acts(dcod_pkg::FA_KEEP, dcod_pkg::FA_KEEP,
                    dcod_pkg::FA_KEEP, dcod_pkg::FA_KEEP);
    exc_allowed = 7'h00;
    operand_count = 3'h0;
    stack_push = 1'b0;
    mode_target = 3'h4;
    case (opcode)
      dcod_pkg::OP_CALL_ARGL: begin
        flag_act = acts(dcod_pkg::FA_CLR, dcod_pkg::FA_CLR,
                        dcod_pkg::FA_CLR, dcod_pkg::FA_CLR);
        exc_allowed[dcod_pkg::EXC_RSV] = 1'b1;
        operand_count = 3'h2;
        stack_push = 1'b1;
      end
      dcod_pkg::OP_CALL_STK: begin
        flag_act = acts(dcod_pkg::FA_CLR, dcod_pkg::FA_CLR,
                        dcod_pkg::FA_CLR, dcod_pkg::FA_CLR);
        exc_allowed[dcod_pkg::EXC_RSV] = 1'b1;
        operand_count = 3'h2;
        stack_push = 1'b1;
      end
      dcod_pkg::OP_INDEX: begin
        flag_act = acts(dcod_pkg::FA_RES, dcod_pkg::FA_RES,
                        dcod_pkg::FA_CLR, dcod_pkg::FA_CLR);
        exc_allowed[dcod_pkg::EXC_SUB] = 1'b1;
        operand_count = 3'h6;
      end
      dcod_pkg::OP_MOVE_BLK: begin
        flag_act = acts(dcod_pkg::FA_CLR, dcod_pkg::FA_SET,
                        dcod_pkg::FA_CLR, dcod_pkg::FA_CLR);
        operand_count = 3'h3;
      end
      dcod_pkg::OP_MOVE_FILL: begin
        flag_act = acts(dcod_pkg::FA_RES, dcod_pkg::FA_RES,
                        dcod_pkg::FA_CLR, dcod_pkg::FA_RES);
        operand_count = 3'h5;
      end
      dcod_pkg::OP_CHG_KERN, dcod_pkg::OP_CHG_EXEC,
      dcod_pkg::OP_CHG_SUPV, dcod_pkg::OP_CHG_USER: begin
        flag_act = acts(dcod_pkg::FA_CLR, dcod_pkg::FA_CLR,
                        dcod_pkg::FA_CLR, dcod_pkg::FA_CLR);
        operand_count = 3'h1;
        stack_push = 1'b1;
        // Kernel 0, executive 1, supervisor 2, user 3.
        mode_target = {1'b0, opcode[1] ? {1'b1, opcode[0]}
                                       : {1'b0, opcode[0]}};
      end
      dcod_pkg::OP_PROBE_RD, dcod_pkg::OP_PROBE_WR: begin
        flag_act = acts(dcod_pkg::FA_CLR, dcod_pkg::FA_RES,
                        dcod_pkg::FA_CLR, dcod_pkg::FA_KEEP);
        operand_count = 3'h3;
      end
      dcod_pkg::OP_ADD_P4: begin
        emulated = 1'b1;
        flag_act = acts(dcod_pkg::FA_RES, dcod_pkg::FA_RES,
                        dcod_pkg::FA_RES, dcod_pkg::FA_CLR);
        exc_allowed[dcod_pkg::EXC_RSV] = 1'b1;
        exc_allowed[dcod_pkg::EXC_DOV] = 1'b1;
        operand_count = 3'h4;
      end
      dcod_pkg::OP_DIV_P: begin
        emulated = 1'b1;
        flag_act = acts(dcod_pkg::FA_RES, dcod_pkg::FA_RES,
                        dcod_pkg::FA_RES, dcod_pkg::FA_CLR);
        exc_allowed[dcod_pkg::EXC_RSV] = 1'b1;
        exc_allowed[dcod_pkg::EXC_DOV] = 1'b1;
        exc_allowed[dcod_pkg::EXC_DDVZ] = 1'b1;
        operand_count = 3'h6;
      end
      dcod_pkg::OP_P_TO_L: begin
        emulated = 1'b1;
        flag_act = acts(dcod_pkg::FA_RES, dcod_pkg::FA_RES,
                        dcod_pkg::FA_RES, dcod_pkg::FA_CLR);
        exc_allowed[dcod_pkg::EXC_RSV] = 1'b1;
        exc_allowed[dcod_pkg::EXC_IOV] = 1'b1;
        operand_count = 3'h3;
      end
      dcod_pkg::OP_CRC: begin
        emulated = 1'b1;
        flag_act = acts(dcod_pkg::FA_RES, dcod_pkg::FA_RES,
                        dcod_pkg::FA_CLR, dcod_pkg::FA_CLR);
        operand_count = 3'h4;
      end
      dcod_pkg::OP_EDIT_P: begin
        emulated = 1'b1;
        flag_act = acts(dcod_pkg::FA_RES, dcod_pkg::FA_RES,
                        dcod_pkg::FA_RES, dcod_pkg::FA_RES);
        exc_allowed[dcod_pkg::EXC_RSV] = 1'b1;
        exc_allowed[dcod_pkg::EXC_DOV] = 1'b1;
        operand_count = 3'h4;
      end
      dcod_pkg::OP_MATCH: begin
        emulated = 1'b1;
        flag_act = acts(dcod_pkg::FA_CLR, dcod_pkg::FA_RES,
                        dcod_pkg::FA_CLR, dcod_pkg::FA_CLR);
        operand_count = 3'h4;
      end
      dcod_pkg::OP_XLAT_ESC: begin
        emulated = 1'b1;
        flag_act = acts(dcod_pkg::FA_RES, dcod_pkg::FA_RES,
                        dcod_pkg::FA_RES, dcod_pkg::FA_RES);
        operand_count = 3'h6;
      end
      default: begin
        // Unassigned opcodes raise the reserved instruction class.
        known = 1'b0;
        exc_allowed[dcod_pkg::EXC_RSVI] = 1'b1;
      end
    endcase
  end
endmodule : dcod_table
`default_nettype wire

// ### hdl/dcod_top.sv
// APB-programmed opcode decoder with flag and exception classification.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module dcod_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  ////////////////////////////////////////////////////////////////////////
  // Decode state machine: idle, collecting operands, done.
  typedef enum logic [2:0] {
    DCOD_IDLE = 3'b001,
    DCOD_OPND = 3'b010,
    DCOD_DONE = 3'b100
  } dcod_state_e;

  dcod_state_e state; // Current decode state.
  logic [7:0] opcode; // Opcode last written by software while idle.
  logic [3:0] flags; // Condition flags N Z V C.
  logic [3:0] result_flags; // Result-derived N Z V C supplied by software.
  logic [6:0] exc_req; // Exception events requested by software.
  logic [6:0] exc_seen; // Classified exception of last instruction.
  logic [1:0] cur_mode; // Current access mode, 0 kernel to 3 user.
  logic [1:0] stack_mode; // Mode whose stack takes the push.
  logic emul_go; // Pulse: control passes to emulation routine.
  logic emul_pending; // Sticky: emulation handoff happened.
  logic [2:0] opnd_left; // Operand specifiers still to evaluate.
  logic [7:0] arg_count; // Argument list entries built so far.
  logic [31:0] arg_list [0:7]; // Standard argument list being built.
  logic [31:0] result; // Last written operand value.
  logic wr_en; // APB write access phase.
  logic rd_en; // APB read setup phase; the read mux loads here.

  // Table outputs.
  logic known;
  logic emulated;
  logic [7:0] flag_act;
  logic [6:0] exc_allowed;
  logic [2:0] operand_count;
  logic stack_push;
  logic [2:0] mode_target;

  dcod_table u_table (
    .opcode(opcode),
    .known(known),
    .emulated(emulated),
    .flag_act(flag_act),
    .exc_allowed(exc_allowed),
    .operand_count(operand_count),
    .stack_push(stack_push),
    .mode_target(mode_target)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states; unmapped addresses error out.
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Returns one when the offset is a mapped register.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == dcod_pkg::REG_OPCODE) || (a == dcod_pkg::REG_RESULT) ||
             (a == dcod_pkg::REG_FLAGS) || (a == dcod_pkg::REG_STATUS) ||
             (a == dcod_pkg::REG_EMUL) || (a == dcod_pkg::REG_COUNT);
  endfunction : mapped

  assign pslverr = psel && penable && !mapped(paddr);

  // Per-flag application of the table action to the old and new value.
  function automatic logic apply(input logic [1:0] act, input logic old,
      input logic res);
    case (act)
      dcod_pkg::FA_CLR: apply = 1'b0;
      dcod_pkg::FA_SET: apply = 1'b1;
      dcod_pkg::FA_RES: apply = res;
      default: apply = old;
    endcase
  endfunction : apply

  ////////////////////////////////////////////////////////////////////////
  // Instruction sequencing: an opcode write starts decode, each operand
  // write counts down the specifiers, and the last one completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DCOD_IDLE;
      opnd_left <= 3'h0;
    end else begin
      case (state)
        DCOD_IDLE: begin
          if (wr_en && paddr == dcod_pkg::REG_OPCODE) begin
            state <= DCOD_OPND;
          end
        end
        DCOD_OPND: begin
          // Operand count is known one cycle after the opcode lands.
          if (opnd_left == 3'h0 && arg_count == dcod_pkg::COUNT_RST &&
              operand_count != 3'h0 && !(wr_en &&
              paddr == dcod_pkg::REG_RESULT)) begin
            opnd_left <= operand_count;
          end else if (wr_en && paddr == dcod_pkg::REG_RESULT) begin
            opnd_left <= (opnd_left == 3'h0) ? 3'h0 : opnd_left - 3'h1;
          end
          if (operand_count == 3'h0 || (wr_en &&
              paddr == dcod_pkg::REG_RESULT &&
              {5'h00, opnd_left} <= 8'h01 &&
              arg_count != dcod_pkg::COUNT_RST) ||
              (wr_en && paddr == dcod_pkg::REG_RESULT &&
              operand_count == 3'h1)) begin
            state <= DCOD_DONE;
          end
        end
        DCOD_DONE: begin
          state <= DCOD_IDLE;
        end
        default: state <= DCOD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Argument list build: each operand word is stored in order, so the
  // emulation routine finds a complete list when it is entered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arg_count <= dcod_pkg::COUNT_RST;
      result <= 32'h0000_0000;
    end else if (state == DCOD_IDLE && wr_en &&
                 paddr == dcod_pkg::REG_OPCODE) begin
      // Cleared only when a new instruction is accepted, so the count
      // stays readable while the emulation routine works on the list.
      arg_count <= dcod_pkg::COUNT_RST;
    end else if (state == DCOD_OPND && wr_en &&
                 paddr == dcod_pkg::REG_RESULT) begin
      arg_count <= arg_count + 8'h01;
      result <= pwdata;
    end
  end

  // Argument storage has no reset; it is only read after being written.
  always_ff @(posedge pclk) begin
    if (state == DCOD_OPND && wr_en && paddr == dcod_pkg::REG_RESULT) begin
      arg_list[arg_count[2:0]] <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Opcode, result flags and exception requests written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode <= 8'h01;
      result_flags <= dcod_pkg::FLAGS_RST;
      exc_req <= 7'h00;
    end else if (wr_en && paddr == dcod_pkg::REG_OPCODE &&
                 state == DCOD_IDLE) begin
      opcode <= pwdata[7:0];
      result_flags <= pwdata[11:8];
      exc_req <= pwdata[18:12];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Completion: classify exceptions, then update flags. A fault leaves
  // the flags alone; a trap lets the instruction's flag update stand.
  logic [6:0] next_exc;
  logic is_fault;
  always_comb begin
    next_exc = (exc_req & exc_allowed) |
               (known ? 7'h00 : 7'h40);
    is_fault = |(next_exc & dcod_pkg::FAULT_MASK);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= dcod_pkg::FLAGS_RST;
      exc_seen <= 7'h00;
    end else if (state == DCOD_DONE) begin
      exc_seen <= next_exc;
      if (!is_fault && !emulated) begin
        flags <= {apply(flag_act[7:6], flags[3], result_flags[3]),
                  apply(flag_act[5:4], flags[2], result_flags[2]),
                  apply(flag_act[3:2], flags[1], result_flags[1]),
                  apply(flag_act[1:0], flags[0], result_flags[0])};
      end
    end else if (emul_pending && wr_en && paddr == dcod_pkg::REG_FLAGS) begin
      // Emulation routine returns flags under the same table actions.
      flags <= {apply(flag_act[7:6], flags[3], pwdata[3]),
                apply(flag_act[5:4], flags[2], pwdata[2]),
                apply(flag_act[3:2], flags[1], pwdata[1]),
                apply(flag_act[1:0], flags[0], pwdata[0])};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Emulation handoff: a pulse at completion, plus a sticky flag that
  // software clears by writing one; a new handoff wins over the clear.
  assign emul_go = (state == DCOD_DONE) && emulated && !is_fault;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emul_pending <= 1'b0;
    end else if (emul_go) begin
      emul_pending <= 1'b1;
    end else if (wr_en && paddr == dcod_pkg::REG_EMUL && pwdata[0]) begin
      emul_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode changes push onto the stack of the less privileged of the target
  // and current modes; a larger mode number is less privileged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_mode <= dcod_pkg::MODE_RST;
      stack_mode <= dcod_pkg::MODE_RST;
    end else if (wr_en && paddr == dcod_pkg::REG_STATUS) begin
      cur_mode <= pwdata[1:0];
    end else if (state == DCOD_DONE && stack_push && !is_fault) begin
      if (mode_target[2]) begin
        stack_mode <= cur_mode;
      end else begin
        stack_mode <= (mode_target[1:0] > cur_mode) ? mode_target[1:0]
                                                    : cur_mode;
        cur_mode <= (mode_target[1:0] > cur_mode) ? cur_mode
                                                  : mode_target[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped reads return zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        dcod_pkg::REG_OPCODE: prdata <= {24'h00_0000, opcode};
        dcod_pkg::REG_RESULT: prdata <= result;
        dcod_pkg::REG_FLAGS: prdata <= {28'h000_0000, flags};
        dcod_pkg::REG_STATUS: prdata <= {16'h0000, 1'b0, exc_seen,
            known, emulated, stack_push, 1'b0, stack_mode, cur_mode};
        dcod_pkg::REG_EMUL: prdata <= {24'h00_0000, state == DCOD_IDLE,
            6'h00, emul_pending};
        // With an empty list the last-operand byte reads zero, so an
        // unwritten slot of the argument store never reaches the bus.
        dcod_pkg::REG_COUNT: prdata <= {16'h0000,
            (arg_count == dcod_pkg::COUNT_RST ? 8'h00
             : arg_list[arg_count[2:0] - 3'h1][7:0]), arg_count};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : dcod_top
`default_nettype wire

// ### inc/dcod_pkg.sv
// Package with opcodes, flag actions, exception classes and register map.
package dcod_pkg;
  // Flag action codes per flag: keep, clear, set, from result.
  localparam logic [1:0] FA_KEEP = 2'h0;
  localparam logic [1:0] FA_CLR = 2'h1;
  localparam logic [1:0] FA_SET = 2'h2;
  localparam logic [1:0] FA_RES = 2'h3;
  // Exception class bits.
  localparam int EXC_RSV = 0;
  localparam int EXC_IOV = 1;
  localparam int EXC_DOV = 2;
  localparam int EXC_DDVZ = 3;
  localparam int EXC_SUB = 4;
  localparam int EXC_PRV = 5;
  localparam int EXC_RSVI = 6;
  localparam int EXC_W = 7;
  // Mask of exception classes that are faults (flags suppressed).
  localparam logic [6:0] FAULT_MASK = 7'h61;
  // Opcodes.
  localparam logic [7:0] OP_CALL_ARGL = 8'hFA;
  localparam logic [7:0] OP_CALL_STK = 8'hFB;
  localparam logic [7:0] OP_INDEX = 8'h0A;
  localparam logic [7:0] OP_MOVE_BLK = 8'h28;
  localparam logic [7:0] OP_MOVE_FILL = 8'h2C;
  localparam logic [7:0] OP_CHG_KERN = 8'hBC;
  localparam logic [7:0] OP_CHG_EXEC = 8'hBD;
  localparam logic [7:0] OP_CHG_SUPV = 8'hBE;
  localparam logic [7:0] OP_CHG_USER = 8'hBF;
  localparam logic [7:0] OP_PROBE_RD = 8'h0C;
  localparam logic [7:0] OP_PROBE_WR = 8'h0D;
  localparam logic [7:0] OP_ADD_P4 = 8'h20;
  localparam logic [7:0] OP_DIV_P = 8'h27;
  localparam logic [7:0] OP_P_TO_L = 8'h36;
  localparam logic [7:0] OP_CRC = 8'h0B;
  localparam logic [7:0] OP_EDIT_P = 8'h38;
  localparam logic [7:0] OP_MATCH = 8'h39;
  localparam logic [7:0] OP_XLAT_ESC = 8'h2F;
  // Register byte offsets.
  localparam logic [7:0] REG_OPCODE = 8'h00;
  localparam logic [7:0] REG_RESULT = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_EMUL = 8'h10;
  localparam logic [7:0] REG_COUNT = 8'h14;
  // Reset values.
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] COUNT_RST = 8'h00;
endpackage : dcod_pkg

// ### sim/dcod_apb_host.sv
// Register-bus host model that issues single transfers.
`timescale 1ns/1ns
`default_nettype none
module dcod_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  ////////////////////////////////////////////////////////////
  // Idle bus at time zero.
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Setup, then access held until pready is sampled high.
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Released lines show the inverse, so stale values cannot pass.
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : dcod_apb_host
`default_nettype wire

// ### sim/dcod_top_assertions.sv
// Checker for the decoder's register bus and status read-back.
`timescale 1ns/1ns
`default_nettype none
module dcod_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // Helpers for access phase, read access, read setup and decode.
  logic acc;
  logic rd;
  logic rd_setup;
  logic mapped;
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  // Six aligned words from offset zero are decoded.
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h14);
  ////////////////////////////////////////////////////////////
  ready_high_a: assert property (pready)
    else $error("pready low");
  err_access_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  err_decode_a: assert property (psel && !penable ##1 acc |->
      pslverr == !mapped)
    else $error("pslverr wrong for address");
  rdata_hold_a: assert property ($changed(prdata) |-> $past(rd_setup))
    else $error("prdata moved without read");
  rst_zero_a: assert property ($rose(presetn) |-> prdata == 32'h0)
    else $error("prdata not clear after reset");
  flags_narrow_a:
    assert property (rd && paddr == 8'h08 |-> prdata[31:4] == 28'h0)
    else $error("flags read has upper bits");
  known_rsvi_a:
    assert property (rd && paddr == 8'h0C && prdata[7] |-> !prdata[14])
    else $error("known opcode flagged reserved");
  emul_known_a:
    assert property (rd && paddr == 8'h0C && prdata[6] |-> prdata[7])
    else $error("emulated opcode not known");
  count_range_a:
    assert property (rd && paddr == 8'h14 |-> prdata[7:0] <= 8'h06)
    else $error("argument count too large");
  // Main scenarios worth seeing at least once.
  cover property (acc && pslverr);
  cover property (rd && paddr == 8'h0C && prdata[6]);
  cover property (rd && paddr == 8'h0C && prdata[14]);
endmodule : dcod_top_assertions
bind dcod_top dcod_top_assertions i_dcod_top_assertions (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));
`default_nettype wire

// ### sim/test_dcod_top.sv
// Self-checking bench for the opcode decoder.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin \
  bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, ex, sn); end end
module test_dcod_top;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  wire psel, penable, pwrite, pready, pslverr;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  int bad_count = 0;
  int checks_done = 0;
  logic [31:0] q;
  logic e;
  logic [3:0] flags;
  localparam logic [1:0] K = dcod_pkg::FA_KEEP;
  localparam logic [1:0] C = dcod_pkg::FA_CLR;
  localparam logic [1:0] S = dcod_pkg::FA_SET;
  localparam logic [1:0] R = dcod_pkg::FA_RES;
  // Opcode, operands, NZVC actions, allowed exceptions, known, push, emu.
  typedef struct packed {
    logic [7:0] op; logic [2:0] n; logic [7:0] act; logic [6:0] ok;
    logic kn; logic push; logic emu; } dcod_row_s;
  localparam dcod_row_s ROWS [15] = '{
    '{8'hFA, 3'h2, {C, C, C, C}, 7'h01, 1'h1, 1'h1, 1'h0},
    '{8'hFB, 3'h2, {C, C, C, C}, 7'h01, 1'h1, 1'h1, 1'h0},
    '{8'h0A, 3'h6, {R, R, C, C}, 7'h10, 1'h1, 1'h0, 1'h0},
    '{8'h28, 3'h3, {C, S, C, C}, 7'h00, 1'h1, 1'h0, 1'h0},
    '{8'h2C, 3'h5, {R, R, C, R}, 7'h00, 1'h1, 1'h0, 1'h0},
    '{8'h0C, 3'h3, {C, R, C, K}, 7'h00, 1'h1, 1'h0, 1'h0},
    '{8'h0D, 3'h3, {C, R, C, K}, 7'h00, 1'h1, 1'h0, 1'h0},
    '{8'h20, 3'h4, {R, R, R, C}, 7'h05, 1'h1, 1'h0, 1'h1},
    '{8'h27, 3'h6, {R, R, R, C}, 7'h0D, 1'h1, 1'h0, 1'h1},
    '{8'h36, 3'h3, {R, R, R, C}, 7'h03, 1'h1, 1'h0, 1'h1},
    '{8'h0B, 3'h4, {R, R, C, C}, 7'h00, 1'h1, 1'h0, 1'h1},
    '{8'h38, 3'h4, {R, R, R, R}, 7'h05, 1'h1, 1'h0, 1'h1},
    '{8'h39, 3'h4, {C, R, C, C}, 7'h00, 1'h1, 1'h0, 1'h1},
    '{8'h2F, 3'h6, {R, R, R, R}, 7'h00, 1'h1, 1'h0, 1'h1},
    '{8'hFF, 3'h0, {K, K, K, K}, 7'h00, 1'h0, 1'h0, 1'h0}};
  dcod_row_s r;
  ////////////////////////////////////////////////////////////
  dcod_top i_dcod_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dcod_apb_host i_dcod_apb_host (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Free-running bus clock, 40 ns period.
  initial begin
    forever #20 pclk = ~pclk;
  end
  // Model of one flag update: keep, clear, set or take the result.
  function automatic logic [3:0] apply(input logic [7:0] act,
      input logic [3:0] prev, input logic [3:0] res);
    logic [3:0] f;
    for (int i = 0; i < 4; i++) begin
      case (act[2*i+:2])
        K: f[i] = prev[i];
        C: f[i] = 1'h0;
        S: f[i] = 1'h1;
        default: f[i] = res[i];
      endcase
    end
    return f;
  endfunction : apply
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_dcod_apb_host.xfer(1'h1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_dcod_apb_host.xfer(1'h0, a, 32'h0, q, e);
  endtask : rd
  // Opcode word, then one operand word per specifier, then settle.
  task automatic run(input dcod_row_s x, input logic [6:0] req,
      input logic [3:0] res);
    wr(8'h00, {13'h0, req, res, x.op});
    for (int k = 0; k < x.n; k++) wr(8'h04, 32'h100 + k);
    repeat (2) @(posedge pclk);
  endtask : run
  task automatic check_row(input dcod_row_s x, input logic [6:0] req,
      input logic [3:0] res);
    logic [6:0] exc;
    exc = (req & x.ok) | (x.kn ? 7'h00 : 7'h40);
    run(x, req, res);
    rd(8'h0C);
    `CHK("status", {exc, x.kn, x.emu, x.push}, q[14:5])
    rd(8'h10);
    `CHK("pending", x.emu, q[0])
    if (x.emu) begin
      rd(8'h14);
      `CHK("count", {5'h0, x.n}, q[7:0])
      wr(8'h08, {28'h0, res});
      wr(8'h10, 32'h1);
    end
    // A fault leaves the flags as they were; a trap lets them update.
    if (!(|(exc & dcod_pkg::FAULT_MASK))) flags = apply(x.act, flags, res);
    rd(8'h08);
    `CHK("flags", flags, q[3:0])
  endtask : check_row
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////
  // Watchdog: about twenty times the expected length of the run.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    conclude();
  end
  initial begin
    flags = 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    for (int p = 0; p < 2; p++)
      foreach (ROWS[i]) check_row(ROWS[i], p ? 7'h7E : 7'h00, p ? 4'h5 : 4'hF);
    // An opcode written while operands are awaited is dropped.
    r = ROWS[3];
    r.op = 8'hFA;
    wr(8'h00, {13'h0, 7'h00, 4'hF, 8'h28});
    run(r, 7'h00, 4'hF);
    rd(8'h08);
    `CHK("busy drop", 4'h4, q[3:0])
    rd(8'h00);
    `CHK("busy opcode", 32'h28, q)
    // A reserved operand fault suppresses the flag update.
    run(ROWS[0], 7'h01, 4'hF);
    rd(8'h08);
    `CHK("fault flags", 4'h4, q[3:0])
    rd(8'h0C);
    `CHK("fault class", 7'h01, q[14:8])
    // From supervisor, the stack is that of the lesser privilege.
    for (int m = 0; m < 4; m++) begin
      r = '{8'(8'hBC + m), 3'h1, {C, C, C, C}, 7'h00, 1'h1, 1'h1, 1'h0};
      wr(8'h0C, 32'h2);
      run(r, 7'h00, 4'hF);
      rd(8'h0C);
      `CHK("stack", {1'h1, 1'h0, m > 2 ? 2'h3 : 2'h2}, q[5:2])
      rd(8'h08);
      `CHK("chm flags", 4'h0, q[3:0])
    end
    // Unmapped offsets are refused, mapped ones are not.
    wr(8'h20, 32'h0);
    `CHK("err wr", 1'h1, e)
    rd(8'h18);
    `CHK("err rd", 1'h1, e)
    rd(8'h14);
    `CHK("no err", 1'h0, e)
    // Leave state behind, then reset in mid-run.
    run(ROWS[7], 7'h00, 4'hF);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd(8'h08);
    `CHK("rst flags", 4'h0, q[3:0])
    rd(8'h14);
    `CHK("rst count", 8'h00, q[7:0])
    rd(8'h0C);
    `CHK("rst mode", 2'h0, q[1:0])
    rd(8'h10);
    `CHK("rst pending", 1'h0, q[0])
    conclude();
  end
endmodule : test_dcod_top
`default_nettype wire
